// >>> core/fault_log_plane.sv
// first-change fault plane with freeze, masking and read release
// assumes levels arrive already registered in the clk domain
`timescale 1ns/10ps
`include "status_fault_map.svh"
module fault_log_plane #(
    parameter int WIDTH = 12
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clkEn,
    // monitored levels and masks
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] mask,
    // read release
    input  wire logic             clear,
    // logged plane
    output logic      [WIDTH-1:0] logBits,
    output logic                  anyFault
);
    logic [WIDTH-1:0] maskedLevel;
    logic             change;

    if (WIDTH < 1) begin : g_width_check
        $error("fault_log_plane needs at least one monitored function");
    end

    assign maskedLevel = level & ~mask;
    // masked lanes are left out, so setting a mask alone never raises the flag
    assign change = ~anyFault && (((maskedLevel ^ logBits) & ~mask) != '0);

    // frozen plane still drops masked bits so they read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            logBits <= `RESET_LOG;
        end else if (clkEn) begin
            if (anyFault) begin
                logBits <= logBits & ~mask;
            end else begin
                logBits <= maskedLevel;
            end
        end
    end

    // set wins over clear, although while set the plane is frozen anyway
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            anyFault <= 1'b0;
        end else if (clkEn) begin
            anyFault <= change | (anyFault & ~clear);
        end
    end

    chk_first_change_logged: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && change |=> anyFault && logBits == $past(maskedLevel))
        else $error("first change not logged with flag");

    chk_plane_frozen: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && anyFault && !clear && $stable(mask) |=> anyFault && $stable(logBits))
        else $error("plane moved while flag set");

    chk_masked_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(clkEn) && $stable(mask) |-> (logBits & mask) == '0)
        else $error("masked log bit not zero");
endmodule

// >>> core/supervisor_status_fault_log.sv
// supervisor status, fault log and fault mask registers behind the management port
// assumes the serial bus front end gives one-cycle read and write strobes with address
`timescale 1ns/10ps
`include "status_fault_map.svh"
module supervisor_status_fault_log
    import status_fault_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // monitored functions
    input  wire logic [6:0]  supplyFault,
    input  wire logic        watchdogTimeout,
    input  wire logic [3:0]  generalInput,
    input  wire logic [8:0]  driveOutput,
    // management register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    output logic             regRvalid
);
    supply_vec_t     statusSupply;
    input_wdog_vec_t statusInput;
    logic [8:0]      statusDrive;
    supply_vec_t     maskSupply;
    input_wdog_vec_t maskInput;
    plane_vec_t      logBits;
    logic            anyFault;
    logic            logClear;
    reg_byte_t       next_rdata;

    // live status sampled each enabled cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statusSupply <= supply_vec_t'(`RESET_BYTE);
            statusInput  <= input_wdog_vec_t'(`RESET_BYTE);
            statusDrive  <= 9'h000;
        end else if (clkEn) begin
            statusSupply <= supplyFault;
            statusInput  <= {watchdogTimeout, generalInput};
            statusDrive  <= driveOutput;
        end
    end

    // only defined mask bits are stored, reserved write bits fall away
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            maskSupply <= supply_vec_t'(`RESET_BYTE);
            maskInput  <= input_wdog_vec_t'(`RESET_BYTE);
        end else if (clkEn && regWrite) begin
            if (regAddr == `OFS_SUPPLY_FAULT_MASK) begin
                maskSupply <= regWdata[6:0];
            end
            if (regAddr == `OFS_INPUT_WDOG_MASK) begin
                maskInput <= regWdata[4:0];
            end
        end
    end

    // the release relies on the host holding off this read until the flag is seen
    assign logClear = regRead && (regAddr == `OFS_INPUT_WDOG_LOG);

    fault_log_plane #(
        .WIDTH(12)
    ) u_plane (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .level    ({statusInput, statusSupply}),
        .mask     ({maskInput, maskSupply}),
        .clear    (logClear),
        .logBits  (logBits),
        .anyFault (anyFault)
    );

    always_comb begin
        next_rdata = `RESET_BYTE;
        unique case (regAddr)
            `OFS_SUPPLY_FAULT_MASK:   next_rdata = {1'b0, maskSupply};
            `OFS_INPUT_WDOG_MASK:     next_rdata = {3'h0, maskInput};
            `OFS_SUPPLY_FAULT_STATUS: next_rdata = {1'b0, statusSupply};
            `OFS_INPUT_WDOG_STATUS:   next_rdata = {3'h0, statusInput};
            `OFS_SUPPLY_FAULT_LOG:    next_rdata = {anyFault, logBits[6:0]};
            `OFS_INPUT_WDOG_LOG:      next_rdata = {3'h0, logBits[11:7]};
            `OFS_OUTPUT_STATUS_LOW:   next_rdata = statusDrive[7:0];
            `OFS_OUTPUT_STATUS_HIGH:  next_rdata = {7'h00, statusDrive[8]};
            default:                  next_rdata = `RESET_BYTE;
        endcase
    end

    // read data is captured on the same edge that the release takes the flag down
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata  <= `RESET_BYTE;
            regRvalid <= 1'b0;
        end else if (clkEn) begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= next_rdata;
            end
        end
    end

    chk_supply_status_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_STATUS
        |=> regRvalid && regRdata == {1'b0, $past(statusSupply)})
        else $error("supply status read wrong");

    chk_watchdog_status: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn |=> statusInput[`POS_WATCHDOG] == $past(watchdogTimeout))
        else $error("watchdog status not following timeout");

    chk_input_status_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_STATUS
        |=> regRdata[7:5] == 3'h0 && regRdata[3:0] == $past(statusInput[3:0]))
        else $error("input status read wrong");

    chk_drive_status_lag: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn |=> statusDrive == $past(driveOutput))
        else $error("drive status not one cycle behind pins");

    chk_output_high_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_OUTPUT_STATUS_HIGH
        |=> regRdata == {7'h00, $past(statusDrive[8])})
        else $error("high output status read wrong");

    chk_flag_in_log_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_LOG
        |=> regRdata[`POS_ANY_FAULT_FLAG] == $past(anyFault))
        else $error("flag missing from supply log read");

    chk_second_log_reserved: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_LOG |=> regRdata[7:5] == 3'h0)
        else $error("second log reserved bits not zero");

    chk_mask_reserved_drop: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regWrite && regAddr == `OFS_SUPPLY_FAULT_MASK
        |=> maskSupply == $past(regWdata[6:0]))
        else $error("supply mask write not stored");

    chk_second_mask_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regWrite && regAddr == `OFS_INPUT_WDOG_MASK
        |=> maskInput == $past(regWdata[4:0]))
        else $error("second mask write not stored");

    chk_reset_clears: assert property (
        @(posedge clk)
        !rst_n |=> regRdata == 8'h00 && !regRvalid && !anyFault && maskSupply == 7'h00)
        else $error("reset did not clear registers");

    chk_release_clears_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && logClear && anyFault |=> !anyFault)
        else $error("second log read did not clear flag");

    chk_unmapped_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr[7:4] == 4'h0 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");

    chk_unmapped_high_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr[7:5] == 3'h7
        |=> regRdata == 8'h00)
        else $error("high unmapped read not zero");

    // live status path
    chk_supply_status_live: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn
        |=> statusSupply == $past(supplyFault))
        else $error("supply status not following detectors");

    chk_supply_reserved_bit: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_STATUS
        |=> regRdata[7] == 1'b0)
        else $error("supply status reserved bit not zero");

    // each supply lane is checked from pin to read byte, two enabled edges apart
    for (genvar i = 0; i < 7; i++) begin : g_supply_lane
        chk_supply_lane: assert property (
            @(posedge clk) disable iff (!rst_n)
            $past(clkEn) && $past(rst_n) && clkEn && regRead
            && regAddr == `OFS_SUPPLY_FAULT_STATUS |=> regRdata[i] == $past(supplyFault[i], 2))
            else $error("supply lane read wrong");
    end

    chk_watchdog_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_STATUS
        |=> regRdata[`POS_WATCHDOG] == $past(statusInput[4]))
        else $error("watchdog status read wrong");

    chk_input_level_live: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn
        |=> statusInput[3:0] == $past(generalInput))
        else $error("input status not following pins");

    chk_input_reserved_bits: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_STATUS
        |=> regRdata[7:5] == 3'h0)
        else $error("input status reserved bits not zero");

    chk_output_low_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_OUTPUT_STATUS_LOW
        |=> regRdata == $past(statusDrive[7:0]))
        else $error("low output status read wrong");

    chk_drive_high_live: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn
        |=> statusDrive[8] == $past(driveOutput[8]))
        else $error("output nine status not following pin");

    chk_output_high_reserved: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_OUTPUT_STATUS_HIGH
        |=> regRdata[7:1] == 7'h00)
        else $error("high output reserved bits not zero");

    // fault log path
    chk_flag_sets_on_change: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && !anyFault && ((({statusInput, statusSupply} ^ logBits) & ~{maskInput, maskSupply}) != 12'h000)
        |=> anyFault)
        else $error("unmasked change did not raise flag");

    chk_supply_log_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_LOG
        |=> regRdata[6:0] == $past(logBits[6:0]))
        else $error("supply log read wrong");

    chk_log_follows_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && !anyFault
        |=> logBits[6:0] == $past(statusSupply & ~maskSupply))
        else $error("open supply log not tracking levels");

    chk_watchdog_log_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_LOG
        |=> regRdata[`POS_WATCHDOG] == $past(logBits[11]))
        else $error("watchdog log read wrong");

    chk_input_log_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_LOG
        |=> regRdata[3:0] == $past(logBits[10:7]))
        else $error("input log read wrong");

    chk_input_log_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && !anyFault
        |=> logBits[11:7] == $past(statusInput & ~maskInput))
        else $error("open input log not tracking levels");

    chk_supply_masked_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(clkEn) && $stable(maskSupply)
        |-> (logBits[6:0] & maskSupply) == 7'h00)
        else $error("masked supply log bit not zero");

    chk_input_masked_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(clkEn) && $stable(maskInput)
        |-> (logBits[11:7] & maskInput) == 5'h00)
        else $error("masked input log bit not zero");

    chk_reset_status_zero: assert property (
        @(posedge clk)
        !rst_n
        |=> statusSupply == 7'h00 && statusInput == 5'h00 && statusDrive == 9'h000 && logBits == 12'h000 && maskInput == 5'h00)
        else $error("reset did not clear status and log");

    chk_log_frozen_supply: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && anyFault && $stable(maskSupply)
        |=> logBits[6:0] == $past(logBits[6:0]))
        else $error("supply log moved while latched");

    chk_log_frozen_input: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && anyFault && $stable(maskInput)
        |=> logBits[11:7] == $past(logBits[11:7]))
        else $error("input log moved while latched");

    chk_flag_holds_unread: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && anyFault && !logClear
        |=> anyFault)
        else $error("flag dropped without release read");

    chk_first_log_keeps_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_LOG && anyFault
        |=> anyFault)
        else $error("supply log read cleared flag");

    // mask path
    chk_supply_mask_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_SUPPLY_FAULT_MASK
        |=> regRdata == {1'b0, $past(maskSupply)})
        else $error("supply mask read wrong");

    chk_second_mask_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regRead && regAddr == `OFS_INPUT_WDOG_MASK
        |=> regRdata == {3'h0, $past(maskInput)})
        else $error("second mask read wrong");

    chk_other_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        clkEn && regWrite && regAddr != `OFS_SUPPLY_FAULT_MASK && regAddr != `OFS_INPUT_WDOG_MASK
        |=> $stable(maskSupply) && $stable(maskInput))
        else $error("write to read-only address changed a mask");
endmodule

// >>> inc/status_fault_map.svh
// register offsets, field positions and reset values of the supervisor status bank
// assumes inclusion by bare name from packages and modules
`ifndef STATUS_FAULT_MAP_SVH
`define STATUS_FAULT_MAP_SVH

`define OFS_SUPPLY_FAULT_MASK   8'h9D
`define OFS_INPUT_WDOG_MASK     8'h9E
`define OFS_SUPPLY_FAULT_STATUS 8'hDA
`define OFS_INPUT_WDOG_STATUS   8'hDB
`define OFS_SUPPLY_FAULT_LOG    8'hDC
`define OFS_INPUT_WDOG_LOG      8'hDD
`define OFS_OUTPUT_STATUS_LOW   8'hDE
`define OFS_OUTPUT_STATUS_HIGH  8'hDF

`define POS_ANY_FAULT_FLAG      7
`define POS_WATCHDOG            4
`define POS_OUTPUT_NINE         0
`define RESET_BYTE              8'h00
`define RESET_LOG               12'h000

`endif

// >>> inc/status_fault_pkg.sv
// types shared by the supervisor status and fault log bank
// assumes the map header sits on the include path
package status_fault_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [6:0]  supply_vec_t;
    typedef logic [4:0]  input_wdog_vec_t;
    typedef logic [11:0] plane_vec_t;
endpackage

// >>> testbench/host_model.sv
// host side of the management register port: byte reads and writes
// assumes the bench calls its tasks and that strobes are taken on rising clk
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic       clk,
    // register port towards the device
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWdata,
    output logic            regRead,
    input  wire logic [7:0] regRdata,
    input  wire logic       regRvalid
);
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWdata = 8'h00;
        regRead = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // valid and data are both taken at the edge after the read is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        ok = regRvalid;
        v = regRdata;
    endtask
    // second log read only after the flag shows, so a fresh entry is not erased
    task automatic poll(output logic [7:0] f1, output logic [7:0] f2);
        logic ok;
        f2 = 8'h00;
        rd(8'hDC, f1, ok);
        if (f1[7] === 1'b1) begin
            rd(8'hDD, f2, ok);
        end
    endtask
endmodule

// >>> testbench/tb_supervisor_status_fault_log.sv
// self-checking bench for the supervisor status and fault log bank
// assumes the host model file is compiled first
`timescale 1ns/10ps
module tb_supervisor_status_fault_log;
    import status_fault_pkg::*;
    logic        clk, rst_n, clkEn, watchdogTimeout, regWrite, regRead, regRvalid;
    logic [6:0]  supplyFault;
    logic [3:0]  generalInput;
    logic [8:0]  driveOutput;
    logic [7:0]  regAddr, regWdata, regRdata, d, f1, f2;
    logic        ok;
    int          fails, n_checks;
    logic [7:0]  ofs [10] = '{8'h9D, 8'h9E, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'h00,
                              8'hE0};
    always #10 clk = ~clk;
    host_model u_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
        .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid));
    supervisor_status_fault_log u_supervisor_status_fault_log (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .supplyFault(supplyFault), .watchdogTimeout(watchdogTimeout),
        .generalInput(generalInput), .driveOutput(driveOutput), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
        .regRvalid(regRvalid));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask
    // log needs two enabled edges after a pin change, three leaves margin
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        clkEn = 1'b1;
        supplyFault = 7'h00;
        watchdogTimeout = 1'b0;
        generalInput = 4'h0;
        driveOutput = 9'h000;
        settle(10);
        rst_n <= 1'b1;
        foreach (ofs[i]) rdc(ofs[i], 8'h00);
        @(posedge clk);
        supplyFault <= 7'h55;
        watchdogTimeout <= 1'b1;
        generalInput <= 4'hA;
        driveOutput <= 9'h1A5;
        settle(3);
        rdc(8'hDA, 8'h55);
        rdc(8'hDB, 8'h1A);
        rdc(8'hDE, 8'hA5);
        rdc(8'hDF, 8'h01);
        u_host.poll(f1, f2);
        check(f1, 8'hD5);
        check(f2, 8'h1A);
        rdc(8'hDC, 8'h55);
        // a second change while the flag is up must not reach the log
        @(posedge clk);
        supplyFault <= 7'h54;
        settle(3);
        generalInput <= 4'h0;
        settle(3);
        rdc(8'hDC, 8'hD4);
        rdc(8'hDD, 8'h1A);
        settle(3);
        rdc(8'hDC, 8'hD4);
        rdc(8'hDD, 8'h10);
        u_host.wr(8'h9D, 8'hFF);
        u_host.wr(8'h9E, 8'hFF);
        u_host.wr(8'hDA, 8'hFF);
        rdc(8'h9D, 8'h7F);
        rdc(8'h9E, 8'h1F);
        @(posedge clk);
        supplyFault <= 7'h00;
        watchdogTimeout <= 1'b0;
        generalInput <= 4'hF;
        settle(3);
        rdc(8'hDA, 8'h00);
        rdc(8'hDC, 8'h00);
        rdc(8'hDD, 8'h00);
        u_host.wr(8'h9D, 8'h00);
        u_host.wr(8'h9E, 8'h00);
        settle(3);
        rdc(8'hDC, 8'h80);
        rdc(8'hDD, 8'h0F);
        // with the enable low a read strobe is not taken
        settle(2);
        clkEn <= 1'b0;
        u_host.rd(8'hDC, d, ok);
        check({7'h00, ok}, 8'h00);
        check(d, 8'h0F);
        clkEn <= 1'b1;
        rdc(8'hDC, 8'h00);
        // a reset in mid-run drops a latched entry and the input mask
        supplyFault <= 7'h7F;
        u_host.wr(8'h9E, 8'h1F);
        settle(3);
        rdc(8'hDC, 8'hFF);
        rst_n <= 1'b0;
        settle(2);
        rst_n <= 1'b1;
        supplyFault <= 7'h00;
        generalInput <= 4'h0;
        rdc(8'h9E, 8'h00);
        rdc(8'hDC, 8'h00);
        report_and_stop();
    end
endmodule
